// ==== bench/host_model.sv ====
`timescale 1ns/1ps
module host_model
	import servo_mode_pkg::*;
(
	// Clock
	input wire logic clk,
	// Contacts and sensed speed toward the amplifier
	output contacts_s contacts,
	output logic zero_speed,
	output logic [15:0] speed
);
	initial begin
		contacts = '0;
		zero_speed = 1'b1;
		speed = 16'h0000;
	end
	// Levels change just after an edge so the sync stage sees clean steps
	task automatic put(input contacts_s c, input logic z, input logic [15:0] s);
		@(posedge clk);
		contacts <= c;
		zero_speed <= z;
		speed <= s;
	endtask : put
	// Clear is edge driven, so the contact is first seen off, then on
	task automatic pulse_reset();
		contacts_s c;
		c = contacts;
		c.alarm_reset_input = 1'b0;
		put(c, zero_speed, speed);
		repeat (4) @(posedge clk);
		c.alarm_reset_input = 1'b1;
		put(c, zero_speed, speed);
		repeat (6) @(posedge clk);
		c.alarm_reset_input = 1'b0;
		put(c, zero_speed, speed);
		repeat (6) @(posedge clk);
	endtask : pulse_reset
endmodule : host_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench
	import servo_mode_pkg::*;
;
	logic CLK_SYS = 1'b0, RSTN = 1'b0, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	contacts_s CONTACTS;
	logic [15:0] MOTOR_SPEED, ANALOG_SPEED_LIMIT_INPUT;
	logic [11:0] BUS_VOLTAGE;
	logic CTRL_POWER_OK, FAULT_IN, ZERO_SPEED_FLAG, LIMITING_SPEED_OUTPUT, BASE_DRIVE_EN;
	logic DECEL_STOP, DROOP_CLEAR, HOME_VALID, UNDERVOLTAGE_ALARM, ALARM_ACTIVE, ENC_PULSE, er, seen;
	logic [2:0] ACTIVE_LOOP;
	int error_cnt = 0, num_checks = 0, cyc = 0, tg = 0;
	logic ep;
	typedef struct packed {logic [3:0] mode; logic sel; logic zero_speed_flag; loop_e exp;} row_s;
	row_s rows[10] = '{'{4'h3, 1, 0, LOOP_TORQUE}, '{4'h3, 0, 0, LOOP_SPEED},
		'{4'h3, 1, 1, LOOP_TORQUE}, '{4'h5, 0, 1, LOOP_TORQUE}, '{4'h5, 1, 1, LOOP_POSITION},
		'{4'h5, 0, 1, LOOP_TORQUE}, '{4'h5, 1, 0, LOOP_TORQUE}, '{4'h5, 1, 1, LOOP_TORQUE},
		'{4'h5, 0, 1, LOOP_TORQUE}, '{4'h5, 1, 1, LOOP_POSITION}};
	logic [11:0] thr[3] = '{UV_200_V, UV_100_V, UV_400_V};
	always #5 CLK_SYS = ~CLK_SYS;
	host_model host_model_i (.clk(CLK_SYS), .contacts(CONTACTS), .zero_speed(ZERO_SPEED_FLAG),
		.speed(MOTOR_SPEED));
	servo_mode_ctrl #(.PWR_LOSS_CYCLES(20)) servo_mode_ctrl_i (.*);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk_w
	task automatic chk_b(input logic got, input logic exp, input string m);
		chk_w({31'h0, got}, {31'h0, exp}, m);
	endtask : chk_b
	// Waits on pready only; the bench timeout ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do @(posedge CLK_SYS); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic wr_ctrl(input logic [3:0] m, input logic [1:0] v, input logic [1:0] hs);
		apb(1'b1, CTRL_OFS, {DECEL_RST, 6'h00, hs, 2'h0, v, m});
	endtask : wr_ctrl
	task automatic con(input logic sel, input logic sp1, input logic z, input logic [15:0] s);
		contacts_s c;
		c = '0;
		c.control_mode_select = sel;
		c.speed_select_bit0 = sp1;
		c.servo_enable_input = 1'b1;
		host_model_i.put(c, z, s);
		repeat (6) @(posedge CLK_SYS);
	endtask : con
	// Pulses are caught over a short window instead of at one edge
	task automatic watch(ref logic s);
		seen = 1'b0;
		repeat (8) begin
			@(posedge CLK_SYS);
			seen = seen | s;
		end
	endtask : watch
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA, FAULT_IN} = '0;
		ANALOG_SPEED_LIMIT_INPUT = 16'h0000;
		CTRL_POWER_OK = 1'b1;
		BUS_VOLTAGE = 12'h190;
		repeat (20) @(posedge CLK_SYS);
		RSTN <= 1'b1;
		@(negedge CLK_SYS);
		chk_w({29'h0, ACTIVE_LOOP}, {29'h0, LOOP_SPEED}, "reset loop");
		chk_b(ALARM_ACTIVE, 1'b0, "reset alarm");
		apb(1'b0, PULSE_OFS, 32'h0);
		chk_w(rd, {PULSE_SEL_RST, PULSE_CNT_RST}, "pulse reset");
		apb(1'b0, 8'h20, 32'h0);
		chk_w({31'h0, er}, 32'h1, "unmapped err");
		chk_w(rd, 32'h0, "unmapped data");
		$display("test reset done");
		foreach (rows[i]) begin
			wr_ctrl(rows[i].mode, 2'h0, 2'h0);
			con(rows[i].sel, 1'b0, rows[i].zero_speed_flag, rows[i].zero_speed_flag ? 16'h0000 : 16'h01f4);
			chk_w({29'h0, ACTIVE_LOOP}, {29'h0, rows[i].exp}, "loop");
		end
		$display("test mode table done");
		// Position back to torque must clear droop
		host_model_i.put('0, 1'b1, 16'h0000);
		watch(DROOP_CLEAR);
		chk_b(seen, 1'b1, "droop pulse");
		apb(1'b0, DROOP_OFS, 32'h0);
		chk_w(rd, 32'h0, "droop count");
		wr_ctrl(4'h3, 2'h0, 2'h0);
		apb(1'b1, SPDLIM_OFS, 32'h64);
		con(1'b1, 1'b1, 1'b0, 16'h64);
		chk_b(LIMITING_SPEED_OUTPUT, 1'b1, "internal limit");
		con(1'b1, 1'b1, 1'b0, 16'h63);
		chk_b(LIMITING_SPEED_OUTPUT, 1'b0, "below limit");
		ANALOG_SPEED_LIMIT_INPUT <= 16'h28;
		con(1'b1, 1'b0, 1'b0, 16'h63);
		chk_b(LIMITING_SPEED_OUTPUT, 1'b1, "analog limit");
		con(1'b0, 1'b0, 1'b0, 16'h63);
		chk_b(DECEL_STOP, 1'b1, "decel stop");
		$display("test limit done");
		wr_ctrl(4'h5, 2'h0, 2'h0);
		con(1'b0, 1'b0, 1'b1, 16'h0000);
		con(1'b1, 1'b0, 1'b1, 16'h0000);
		wr_ctrl(4'h5, 2'h0, 2'h2);
		repeat (6) @(posedge CLK_SYS);
		chk_b(HOME_VALID, 1'b1, "home set");
		FAULT_IN <= 1'b1;
		repeat (6) @(posedge CLK_SYS);
		chk_b(ALARM_ACTIVE, 1'b1, "alarm");
		chk_b(BASE_DRIVE_EN, 1'b0, "base off");
		chk_b(HOME_VALID, 1'b0, "home lost");
		host_model_i.pulse_reset();
		chk_b(ALARM_ACTIVE, 1'b1, "cause held");
		FAULT_IN <= 1'b0;
		host_model_i.pulse_reset();
		chk_b(ALARM_ACTIVE, 1'b0, "reset clear");
		$display("test alarm done");
		foreach (thr[v]) begin
			// Park the bus above every threshold while the variant changes
			BUS_VOLTAGE <= 12'h190;
			wr_ctrl(4'h5, v[1:0], 2'h0);
			BUS_VOLTAGE <= thr[v] + 12'h1;
			repeat (6) @(posedge CLK_SYS);
			chk_b(UNDERVOLTAGE_ALARM, 1'b0, "above thr");
			BUS_VOLTAGE <= thr[v];
			repeat (6) @(posedge CLK_SYS);
			chk_b(UNDERVOLTAGE_ALARM, 1'b1, "at thr");
			BUS_VOLTAGE <= thr[v] + 12'h1;
			wr_ctrl(4'h5, v[1:0], 2'h1);
			repeat (6) @(posedge CLK_SYS);
			chk_b(UNDERVOLTAGE_ALARM, 1'b0, "set key");
		end
		BUS_VOLTAGE <= 12'h190;
		wr_ctrl(4'h5, 2'h0, 2'h0);
		CTRL_POWER_OK <= 1'b0;
		repeat (10) @(posedge CLK_SYS);
		CTRL_POWER_OK <= 1'b1;
		repeat (6) @(posedge CLK_SYS);
		chk_b(UNDERVOLTAGE_ALARM, 1'b0, "short dip");
		CTRL_POWER_OK <= 1'b0;
		repeat (30) @(posedge CLK_SYS);
		CTRL_POWER_OK <= 1'b1;
		chk_b(UNDERVOLTAGE_ALARM, 1'b1, "long dip");
		$display("test undervoltage done");
		apb(1'b1, PULSE_OFS, {16'h0002, 16'h0003});
		repeat (20) @(posedge CLK_SYS);
		ep = ENC_PULSE;
		repeat (60) begin
			@(posedge CLK_SYS);
			if (ENC_PULSE !== ep)
				tg++;
			ep = ENC_PULSE;
		end
		chk_w(tg, 32'd10, "pulse period");
		$display("test pulse done");
		final_report();
	end
endmodule : testbench

// ==== rtl/pulse_div.sv ====
`timescale 1ns/1ps
module pulse_div (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [15:0] count_param,
	input wire logic [15:0] select_param,
	output logic tick
);
	logic [31:0] cnt_reg;
	logic [31:0] period;

	// Period from both parameters; a zero product still yields one cycle
	assign period = 32'(count_param) * 32'(select_param);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (cnt_reg + 32'h1 >= period) begin
			cnt_reg <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule : pulse_div

// ==== rtl/servo_mode_ctrl.sv ====
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module servo_mode_ctrl
	import servo_mode_pkg::*;
#(
	parameter int PWR_LOSS_CYCLES = PWR_LOSS_CYC
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Contacts and sensed values from outside
	input wire contacts_s CONTACTS,
	input wire logic [15:0] MOTOR_SPEED,
	input wire logic [15:0] ANALOG_SPEED_LIMIT_INPUT,
	input wire logic CTRL_POWER_OK,
	input wire logic [11:0] BUS_VOLTAGE,
	input wire logic FAULT_IN,
	input wire logic ZERO_SPEED_FLAG,
	// Outputs
	output logic LIMITING_SPEED_OUTPUT,
	output logic BASE_DRIVE_EN,
	output logic DECEL_STOP,
	output logic DROOP_CLEAR,
	output logic HOME_VALID,
	output logic UNDERVOLTAGE_ALARM,
	output logic ALARM_ACTIVE,
	output logic ENC_PULSE,
	output logic [2:0] ACTIVE_LOOP
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisers; speeds and voltage are taken as settled words
	contacts_s c_meta_reg, c_reg;
	logic [2:0] m_meta_reg, m_reg;
	logic [15:0] spd_reg, alim_reg;
	logic [11:0] bus_reg;
	wire logic ctrl_pwr = m_reg[0];
	wire logic fault = m_reg[1];
	wire logic zero_speed_flag = m_reg[2];

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			c_meta_reg <= '0;
			c_reg <= '0;
			m_meta_reg <= 3'h0;
			m_reg <= 3'h0;
			spd_reg <= 16'h0000;
			alim_reg <= 16'h0000;
			bus_reg <= 12'hfff; // High, so an unsampled bus never reads as a collapse
		end else begin
			c_meta_reg <= CONTACTS;
			c_reg <= c_meta_reg;
			m_meta_reg <= {ZERO_SPEED_FLAG, FAULT_IN, CTRL_POWER_OK};
			m_reg <= m_meta_reg;
			spd_reg <= MOTOR_SPEED;
			alim_reg <= ANALOG_SPEED_LIMIT_INPUT;
			bus_reg <= BUS_VOLTAGE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0] ctrl_reg;
	logic [15:0] spdlim_reg, pcnt_reg, psel_reg;
	logic [31:0] droop_reg;
	wire logic [3:0] mode_param = ctrl_reg[CTRL_MODE_LSB +: CTRL_MODE_W];
	wire logic [1:0] variant = ctrl_reg[CTRL_VAR_LSB +: 2];
	wire logic [15:0] decel = ctrl_reg[CTRL_DECEL_LSB +: 16];
	wire logic apb_wr = PSEL && PENABLE && PWRITE;
	wire logic apb_rd = PSEL && !PENABLE && !PWRITE;
	wire logic panel_set = apb_wr && PADDR == CTRL_OFS && PWDATA[CTRL_PANEL_SET];
	logic bad_addr;

	always_comb begin
		bad_addr = !(PADDR == CTRL_OFS || PADDR == SPDLIM_OFS || PADDR == PULSE_OFS ||
			PADDR == STATUS_OFS || PADDR == ALARM_OFS || PADDR == DROOP_OFS);
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_reg <= CTRL_RST | {DECEL_RST, 16'h0000};
			spdlim_reg <= SPDLIM_RST;
			pcnt_reg <= PULSE_CNT_RST;
			psel_reg <= PULSE_SEL_RST;
		end else if (apb_wr) begin
			case (PADDR)
				CTRL_OFS: ctrl_reg <= PWDATA & ~(32'h1 << CTRL_PANEL_SET);
				SPDLIM_OFS: spdlim_reg <= PWDATA[15:0];
				PULSE_OFS: begin
					pcnt_reg <= PWDATA[15:0];
					psel_reg <= PWDATA[31:16];
				end
				default: ;
			endcase
		end
	end

	// Zero wait states: answer in the access phase, read data set in setup
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && bad_addr;
			if (apb_rd) begin
				case (PADDR)
					CTRL_OFS: PRDATA <= ctrl_reg;
					SPDLIM_OFS: PRDATA <= {16'h0000, spdlim_reg};
					PULSE_OFS: PRDATA <= {psel_reg, pcnt_reg};
					STATUS_OFS: PRDATA <= {24'h0, HOME_VALID, DECEL_STOP,
						LIMITING_SPEED_OUTPUT, BASE_DRIVE_EN, 1'b0, ACTIVE_LOOP};
					ALARM_OFS: PRDATA <= {30'h0, UNDERVOLTAGE_ALARM, ALARM_ACTIVE};
					DROOP_OFS: PRDATA <= droop_reg;
					default: PRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode selection
	loop_e loop_reg, loop_next;
	logic sel_prev_reg, stale_reg;
	wire logic sel = c_reg.control_mode_select;
	wire logic toggled = sel != sel_prev_reg;

	always_comb begin
		case (mode_param)
			MODE_SPD_TRQ: loop_next = sel ? LOOP_TORQUE : LOOP_SPEED;
			MODE_TRQ_POS: begin
				// Change only at zero speed and only if no toggle was seen while moving
				if (zero_speed_flag && !stale_reg && !(toggled && !zero_speed_flag))
					loop_next = sel ? LOOP_POSITION : LOOP_TORQUE;
				else
					loop_next = loop_reg;
			end
			default: loop_next = loop_reg;
		endcase
	end

	// A toggle seen above zero speed marks the request stale until a toggle at zero speed
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			sel_prev_reg <= 1'b0;
			stale_reg <= 1'b0;
		end else begin
			sel_prev_reg <= sel;
			if (toggled)
				stale_reg <= !zero_speed_flag;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN)
			loop_reg <= LOOP_SPEED;
		else
			loop_reg <= loop_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Droop counter and deceleration stop
	logic [15:0] decel_cnt_reg;
	wire logic leave_pos = loop_reg == LOOP_POSITION && loop_next == LOOP_TORQUE;
	wire logic enter_spd = loop_reg != LOOP_SPEED && loop_next == LOOP_SPEED;

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			droop_reg <= 32'h0000_0000;
			DROOP_CLEAR <= 1'b0;
		end else begin
			DROOP_CLEAR <= leave_pos;
			if (leave_pos)
				droop_reg <= 32'h0000_0000;
			else if (loop_reg == LOOP_POSITION && ENC_PULSE)
				droop_reg <= droop_reg + 32'h1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			decel_cnt_reg <= 16'h0000;
			DECEL_STOP <= 1'b0;
		end else if (enter_spd && !c_reg.forward_start_input && !c_reg.reverse_start_input) begin
			decel_cnt_reg <= decel;
			DECEL_STOP <= 1'b1;
		end else if (decel_cnt_reg != 16'h0000) begin
			decel_cnt_reg <= decel_cnt_reg - 16'h1;
		end else begin
			DECEL_STOP <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Speed limit
	wire logic [15:0] limit = c_reg.speed_select_bit0 ? spdlim_reg : alim_reg;

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN)
			LIMITING_SPEED_OUTPUT <= 1'b0;
		else
			LIMITING_SPEED_OUTPUT <= loop_reg == LOOP_TORQUE && spd_reg >= limit;
	end

	////////////////////////////////////////////////////////////////////////
	// Alarms
	logic [31:0] loss_cnt_reg;
	logic res_prev_reg;
	logic [11:0] uv_thr;
	logic uv_cause;

	always_comb begin
		case (variant)
			VAR_100: uv_thr = UV_100_V;
			VAR_400: uv_thr = UV_400_V;
			default: uv_thr = UV_200_V;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN)
			loss_cnt_reg <= 32'h0000_0000;
		else if (ctrl_pwr)
			loss_cnt_reg <= 32'h0000_0000;
		else if (loss_cnt_reg < PWR_LOSS_CYCLES)
			loss_cnt_reg <= loss_cnt_reg + 32'h1;
	end

	assign uv_cause = loss_cnt_reg >= PWR_LOSS_CYCLES || bus_reg <= uv_thr;
	wire logic cause = uv_cause || fault;
	wire logic res_rise = c_reg.alarm_reset_input && !res_prev_reg;
	wire logic clr_req = res_rise || panel_set;

	// Power cycling is the chip reset; set wins over a clear in the same cycle
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			res_prev_reg <= 1'b0;
			ALARM_ACTIVE <= 1'b0;
			UNDERVOLTAGE_ALARM <= 1'b0;
		end else begin
			res_prev_reg <= c_reg.alarm_reset_input;
			if (cause) begin
				ALARM_ACTIVE <= 1'b1;
				UNDERVOLTAGE_ALARM <= UNDERVOLTAGE_ALARM | uv_cause;
			end else if (clr_req) begin
				ALARM_ACTIVE <= 1'b0;
				UNDERVOLTAGE_ALARM <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN)
			BASE_DRIVE_EN <= 1'b0;
		else
			BASE_DRIVE_EN <= c_reg.servo_enable_input && !ALARM_ACTIVE && !cause;
	end

	// Home is set by software through the control word, lost on any alarm
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN)
			HOME_VALID <= 1'b0;
		else if (cause || ALARM_ACTIVE)
			HOME_VALID <= 1'b0;
		else if (apb_wr && PADDR == CTRL_OFS && PWDATA[CTRL_INC_POS])
			HOME_VALID <= 1'b1;
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN)
			ACTIVE_LOOP <= 3'h1;
		else
			ACTIVE_LOOP <= loop_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// Encoder pulse output
	logic tick;

	pulse_div u_div (
		.clk(CLK_SYS),
		.rstn(RSTN),
		.count_param(pcnt_reg),
		.select_param(psel_reg),
		.tick(tick)
	);

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN)
			ENC_PULSE <= 1'b0;
		else if (tick)
			ENC_PULSE <= !ENC_PULSE;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_base_off_alarm: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		ALARM_ACTIVE |=> !BASE_DRIVE_EN) else $error("base drive on during alarm");
	a_clear_refused: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		cause |=> ALARM_ACTIVE) else $error("alarm cleared with cause present");
	a_droop_reset: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		leave_pos |=> droop_reg == 32'h0 && DROOP_CLEAR) else $error("droop not cleared");
	a_trqpos_gate: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		mode_param == MODE_TRQ_POS && !zero_speed_flag |=> $stable(loop_reg)) else $error("change moving");
	a_spdtrq_any: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		mode_param == MODE_SPD_TRQ && sel |=> loop_reg == LOOP_TORQUE) else $error("no torque");
	a_limit_flag: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		loop_reg == LOOP_TORQUE && spd_reg >= limit |=> LIMITING_SPEED_OUTPUT) else $error("vlim");
	sequence s_bus_low;
		bus_reg <= uv_thr;
	endsequence
	a_uv_bus: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		s_bus_low |=> UNDERVOLTAGE_ALARM) else $error("undervoltage missed");
	a_home_lost: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		ALARM_ACTIVE |=> !HOME_VALID) else $error("home kept after alarm");
endmodule : servo_mode_ctrl

// ==== rtl/servo_mode_pkg.sv ====
package servo_mode_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SPDLIM_OFS = 8'h04;
	localparam logic [7:0] PULSE_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	localparam logic [7:0] ALARM_OFS = 8'h10;
	localparam logic [7:0] DROOP_OFS = 8'h14;

	// Mode parameter encodings
	localparam logic [3:0] MODE_SPD_TRQ = 4'h3;
	localparam logic [3:0] MODE_TRQ_POS = 4'h5;

	// Control field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W = 4;
	localparam int CTRL_VAR_LSB = 4;
	localparam int CTRL_PANEL_SET = 8;
	localparam int CTRL_INC_POS = 9;
	localparam int CTRL_DECEL_LSB = 16;

	// Supply variant thresholds in volts
	localparam logic [1:0] VAR_200 = 2'h0;
	localparam logic [1:0] VAR_100 = 2'h1;
	localparam logic [1:0] VAR_400 = 2'h2;
	localparam logic [11:0] UV_200_V = 12'd200;
	localparam logic [11:0] UV_100_V = 12'd158;
	localparam logic [11:0] UV_400_V = 12'd380;

	// Power loss timing
	localparam int CLK_MHZ = 100;
	localparam int PWR_LOSS_MS = 60;
	localparam int PWR_LOSS_CYC = PWR_LOSS_MS * 1000 * CLK_MHZ;

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0003;
	localparam logic [15:0] SPDLIM_RST = 16'h0000;
	localparam logic [15:0] PULSE_CNT_RST = 16'h0fa0;
	localparam logic [15:0] PULSE_SEL_RST = 16'h0001;
	localparam logic [15:0] DECEL_RST = 16'h0100;

	// Active control loop, one-hot
	typedef enum logic [2:0] {
		LOOP_SPEED = 3'b001,
		LOOP_TORQUE = 3'b010,
		LOOP_POSITION = 3'b100
	} loop_e;

	// Contact inputs from the host
	typedef struct packed {
		logic control_mode_select;
		logic forward_start_input;
		logic reverse_start_input;
		logic speed_select_bit0;
		logic alarm_reset_input;
		logic servo_enable_input;
	} contacts_s;

endpackage : servo_mode_pkg
